// *** rtl/dcs_consts.svh ***
// Purpose: named constants for the disk controller status block
// Assumes: apb byte addresses, 32-bit data
// Notes: included by bare name
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH
`define DCS_ADDR_STATUS 12'h000
`define DCS_ADDR_IRQ_STAT 12'h004
`define DCS_ADDR_IRQ_MASK 12'h008
`define DCS_ADDR_CMD 12'h00c
`define DCS_ADDR_EVENT 12'h010
`define DCS_BIT_NRDY 7
`define DCS_BIT_PROT 6
`define DCS_BIT_HEAD 5
`define DCS_BIT_SEEK 4
`define DCS_BIT_CRC 3
`define DCS_BIT_TRK 2
`define DCS_BIT_IDX 1
`define DCS_BIT_BUSY 0
`define DCS_IRQ_DONE 0
`define DCS_IRQ_REFUSED 1
`define DCS_IRQ_LOST 2
`define DCS_IRQ_W 3
`define DCS_CLASS_W 3
`define DCS_EV_W 8
`define DCS_EV_DONE 0
`define DCS_EV_SEEK_ERR 1
`define DCS_EV_CRC_ERR 2
`define DCS_EV_RNF 3
`define DCS_EV_DELETED 4
`define DCS_EV_WR_FAULT 5
`define DCS_EV_LOST 6
`define DCS_EV_WPROT 7
`define DCS_STAT_RST 8'h00
`define DCS_PIN_IDLE 5'h0b
`endif

// *** rtl/dcs_pkg.sv ***
// Purpose: types for the disk controller status block
// Assumes: dcs_consts.svh defines widths
// Notes: nothing here is imported
`include "dcs_consts.svh"
package dcs_pkg;
  // command class written into the command register
  typedef enum logic [`DCS_CLASS_W-1:0] {
    DCS_CL_STEP = 3'h0,
    DCS_CL_RD_ADDR = 3'h1,
    DCS_CL_RD_SECT = 3'h2,
    DCS_CL_RD_TRK = 3'h3,
    DCS_CL_WR_SECT = 3'h4,
    DCS_CL_WR_TRK = 3'h5,
    DCS_CL_FORCE = 3'h6
  } dcs_class_type;
  // one-hot busy state
  typedef enum logic [1:0] {
    DCS_ST_IDLE = 2'b01,
    DCS_ST_BUSY = 2'b10
  } dcs_state_type;
  // live drive inputs, already synchronised
  typedef struct packed {
    logic ready;
    logic wprot_n;
    logic head_load_timing_in;
    logic trk0_n;
    logic index_n;
  } dcs_drive_type;
endpackage

// *** rtl/dcs_status.sv ***
// Purpose: status word of the floppy controller, reachable over apb
// Assumes: sequencer pulses event bits; drive pins asynchronous
// Notes: reading never alters status
//
// Notes on behaviour
// [R01] bit 7 is not-ready: inverted ready ORed with master reset, all classes
// [R02] sector or track read/write commands are refused while not ready
// [R03] seek class bit 6 shows inverted write protect pin
// [R04] seek class bit 5 is head load output ANDed with head timing
// [R05] seek class bit 4 flags unverified track, cleared on new command
// [R06] seek class bit 3 flags id field crc mismatch
// [R07] seek class bit 2 shows inverted track zero input
// [R08] seek class bit 1 shows inverted index pulse input
// [R09] bit 0 is busy while a command executes, all classes
// [R10] write class bit 6 reports protection, cleared on update; reads give zero
// [R11] sector read bit 5 holds record type: one means deleted data mark
// [R12] write class bit 5 reports write fault, cleared on new command
// [R13] sector and address commands bit 4 is record not found, cleared on update
// [R14] sector and address commands bit 3 is crc error, cleared on update
// [R15] unserviced data request sets lost data bit 2, cleared on update
// [R16] read/write bit 1 mirrors the data request output, cleared on update
// [R17] any accepted non-force command sets busy and clears the other status bits; the code clears only the sticky flags and data request bit
// [R18] status is read-only and reading it changes nothing
`timescale 1ns/1ps
`include "dcs_consts.svh"
module dcs_status (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic master_reset_in_i,
  input wire logic drive_ready_i,
  input wire logic write_protect_in_n_i,
  input wire logic head_load_timing_in_i,
  input wire logic track_zero_in_n_i,
  input wire logic index_pulse_in_n_i,
  input wire logic head_load_out_i,
  input wire logic data_request_out_i,
  input wire logic [`DCS_EV_W-1:0] event_i,
  output logic cmd_start_o,
  output logic [`DCS_CLASS_W-1:0] cmd_class_o,
  output logic irq_o
);
  localparam int NSYNC = 5;
  // three-stage synchronisers; stage 1 feeds only stage 2
  logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
  wire [NSYNC-1:0] pin_raw = {drive_ready_i, write_protect_in_n_i, head_load_timing_in_i,
                              track_zero_in_n_i, index_pulse_in_n_i};
  wire [NSYNC-1:0] agree = ~(s2_ff ^ s3_ff);
  wire [NSYNC-1:0] nxt_pin = (agree & s3_ff) | (~agree & pin_ff);
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // idle pin levels, so active-low pins show no false flag after reset
      s1_ff <= `DCS_PIN_IDLE;
      s2_ff <= `DCS_PIN_IDLE;
      s3_ff <= `DCS_PIN_IDLE;
      pin_ff <= `DCS_PIN_IDLE;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= nxt_pin;
    end
  end
  dcs_pkg::dcs_drive_type drv;
  assign drv = pin_ff;
  // master reset synchroniser, same three-stage scheme
  logic [2:0] mr_ff;
  logic mr_q_ff;
  wire nxt_mr_q = (mr_ff[1] == mr_ff[2]) ? mr_ff[2] : mr_q_ff;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mr_ff <= 3'h0;
      mr_q_ff <= 1'b0;
    end else begin
      mr_ff <= {mr_ff[1:0], master_reset_in_i};
      mr_q_ff <= nxt_mr_q;
    end
  end

  // apb decode; zero wait states, unmapped address gets pslverr
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire hit_stat = paddr_i == `DCS_ADDR_STATUS;
  wire hit_istat = paddr_i == `DCS_ADDR_IRQ_STAT;
  wire hit_imask = paddr_i == `DCS_ADDR_IRQ_MASK;
  wire hit_cmd = paddr_i == `DCS_ADDR_CMD;
  wire hit_ev = paddr_i == `DCS_ADDR_EVENT;
  wire mapped = hit_stat | hit_istat | hit_imask | hit_cmd | hit_ev;
  // [R18] status is read-only: writes to it are errors
  wire bad = ~mapped | (pwrite_i & (hit_stat | hit_ev));
  assign pready_o = 1'b1;
  assign pslverr_o = acc & bad;
  wire cmd_wr = wr & hit_cmd;
  dcs_pkg::dcs_class_type new_cls;
  assign new_cls = dcs_pkg::dcs_class_type'(pwdata_i[`DCS_CLASS_W-1:0]);
  wire is_force = new_cls == dcs_pkg::DCS_CL_FORCE;
  wire is_step = new_cls == dcs_pkg::DCS_CL_STEP;
  wire not_ready = ~drv.ready | mr_q_ff;
  // [R02] type II and III refused when drive not ready
  wire refuse = cmd_wr & ~is_force & ~is_step & not_ready;
  wire accept = cmd_wr & ~is_force & ~refuse;

  // command state machine
  dcs_pkg::dcs_state_type st_ff, nxt_st;
  dcs_pkg::dcs_class_type cls_ff, nxt_cls;
  wire done = event_i[`DCS_EV_DONE];
  always_comb begin
    nxt_st = st_ff;
    nxt_cls = cls_ff;
    case (st_ff)
      dcs_pkg::DCS_ST_IDLE: begin
        if (accept) begin
          nxt_st = dcs_pkg::DCS_ST_BUSY;
          nxt_cls = new_cls;
        end
      end
      dcs_pkg::DCS_ST_BUSY: begin
        if (accept) begin
          nxt_cls = new_cls;
        end else if (done | (cmd_wr & is_force)) begin
          nxt_st = dcs_pkg::DCS_ST_IDLE;
        end
      end
      default: nxt_st = dcs_pkg::DCS_ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= dcs_pkg::DCS_ST_IDLE;
      cls_ff <= dcs_pkg::DCS_CL_STEP;
    end else begin
      st_ff <= nxt_st;
      cls_ff <= nxt_cls;
    end
  end
  assign cmd_start_o = accept;
  assign cmd_class_o = cls_ff;
  wire busy = st_ff == dcs_pkg::DCS_ST_BUSY;

  // sticky error flags; an event in the accept cycle still lands
  logic seek_ff, crc_ff, rnf_ff, del_ff, wflt_ff, lost_ff, wprot_ff;
  // [R17] accept clears the flags, set wins over clear
  wire [6:0] ev_hit = {event_i[`DCS_EV_SEEK_ERR], event_i[`DCS_EV_CRC_ERR],
                       event_i[`DCS_EV_RNF], event_i[`DCS_EV_DELETED],
                       event_i[`DCS_EV_WR_FAULT], event_i[`DCS_EV_LOST],
                       event_i[`DCS_EV_WPROT]};
  wire [6:0] cur = {seek_ff, crc_ff, rnf_ff, del_ff, wflt_ff, lost_ff, wprot_ff};
  // [R05] [R12] [R13] [R15] cleared when updated
  wire [6:0] nxt_flags = ev_hit | (accept ? 7'h00 : cur);
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {seek_ff, crc_ff, rnf_ff, del_ff, wflt_ff, lost_ff, wprot_ff} <= 7'h00;
    end else begin
      {seek_ff, crc_ff, rnf_ff, del_ff, wflt_ff, lost_ff, wprot_ff} <= nxt_flags;
    end
  end
  // data request cleared on update until sequencer raises it again
  logic drq_en_ff;
  wire nxt_drq_en = accept ? 1'b0 : (drq_en_ff | ~data_request_out_i);
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drq_en_ff <= 1'b0;
    end else begin
      drq_en_ff <= nxt_drq_en;
    end
  end

  // status word assembly by class
  wire c_step = cls_ff == dcs_pkg::DCS_CL_STEP;
  wire c_rsec = cls_ff == dcs_pkg::DCS_CL_RD_SECT;
  wire c_radr = cls_ff == dcs_pkg::DCS_CL_RD_ADDR;
  wire c_wsec = cls_ff == dcs_pkg::DCS_CL_WR_SECT;
  wire c_wtrk = cls_ff == dcs_pkg::DCS_CL_WR_TRK;
  wire c_wr = c_wsec | c_wtrk;
  wire c_id = c_rsec | c_radr | c_wsec;
  logic [7:0] st_word;
  always_comb begin
    st_word = `DCS_STAT_RST;
    // [R01] not ready in every class
    st_word[`DCS_BIT_NRDY] = not_ready;
    // [R09] busy in every class
    st_word[`DCS_BIT_BUSY] = busy;
    if (c_step) begin
      // [R03] protect from inverted pin
      st_word[`DCS_BIT_PROT] = ~drv.wprot_n;
      // [R04] head loaded and engaged
      st_word[`DCS_BIT_HEAD] = head_load_out_i & drv.head_load_timing_in;
      // [R05] seek error flag
      st_word[`DCS_BIT_SEEK] = seek_ff;
      // [R06] id crc during verify
      st_word[`DCS_BIT_CRC] = crc_ff;
      // [R07] track zero from inverted pin
      st_word[`DCS_BIT_TRK] = ~drv.trk0_n;
      // [R08] index from inverted pin
      st_word[`DCS_BIT_IDX] = ~drv.index_n;
    end else begin
      // [R10] protect on writes only
      st_word[`DCS_BIT_PROT] = c_wr & wprot_ff;
      // [R11] [R12] record type or write fault
      st_word[`DCS_BIT_HEAD] = (c_rsec & del_ff) | (c_wr & wflt_ff);
      // [R13] record not found
      st_word[`DCS_BIT_SEEK] = c_id & rnf_ff;
      // [R14] crc error, id or data decided by bit 4
      st_word[`DCS_BIT_CRC] = c_id & crc_ff;
      // [R15] lost data
      st_word[`DCS_BIT_TRK] = lost_ff;
      // [R16] mirror of data request
      st_word[`DCS_BIT_IDX] = data_request_out_i & drq_en_ff;
    end
  end

  // interrupt status, write one to clear, set wins
  logic [`DCS_IRQ_W-1:0] istat_ff, imask_ff;
  wire [`DCS_IRQ_W-1:0] irq_ev = {event_i[`DCS_EV_LOST], refuse, busy & ~nxt_st[1]};
  wire [`DCS_IRQ_W-1:0] w1c = (wr & hit_istat) ? pwdata_i[`DCS_IRQ_W-1:0] : 3'h0;
  wire [`DCS_IRQ_W-1:0] nxt_istat = irq_ev | (istat_ff & ~w1c);
  wire [`DCS_IRQ_W-1:0] nxt_imask = (wr & hit_imask) ? pwdata_i[`DCS_IRQ_W-1:0] : imask_ff;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      istat_ff <= 3'h0;
      imask_ff <= 3'h0;
    end else begin
      istat_ff <= nxt_istat;
      imask_ff <= nxt_imask;
    end
  end
  assign irq_o = |(istat_ff & imask_ff);

  // read mux; registered data, no side effects
  wire [31:0] rd_mux = hit_stat ? {24'h000000, st_word} :
                       hit_istat ? {29'h00000000, istat_ff} :
                       hit_imask ? {29'h00000000, imask_ff} :
                       hit_cmd ? {29'h00000000, cls_ff} : 32'h00000000;
  logic [31:0] rdata_ff;
  wire [31:0] nxt_rdata = (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : rdata_ff;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign prdata_o = rdata_ff;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_busy_on_accept: assert property (accept |=> busy) // [R17]
    else $error("busy not set after accept");
  a_refuse_idle: assert property (refuse && !busy |=> !busy) // [R02]
    else $error("refused command started");
  a_not_ready_bit: assert property (st_word[7] == (~drv.ready | mr_q_ff)) // [R01]
    else $error("not ready bit wrong");
  a_flags_cleared: assert property (accept && !(|ev_hit) |=> !seek_ff && !rnf_ff && !lost_ff) // [R05]
    else $error("flags not cleared on update");
  a_lost_sticky: assert property (event_i[`DCS_EV_LOST] |=> lost_ff) // [R15]
    else $error("lost data not held");
  a_head_loaded: assert property (c_step |-> st_word[5] == (head_load_out_i & drv.head_load_timing_in)) // [R04]
    else $error("head loaded wrong");
  a_read_prot_zero: assert property (c_rsec |-> !st_word[6]) // [R10]
    else $error("protect set on read");
  a_done_idle: assert property (busy && done && !accept |=> !busy) // [R09]
    else $error("busy held after done");
  a_read_no_effect: assert property (acc && !pwrite_i && !(|ev_hit) && !accept |=> $stable(cur)) // [R18]
    else $error("read changed status");

  // command lifecycle steps: accepted now, busy on the next edge
  sequence s_accepted;
    accept;
  endsequence
  sequence s_busy_next;
    ##1 busy;
  endsequence

  // a start always leads to busy
  a_start_busy: assert property (s_accepted |-> s_busy_next) // [R17]
    else $error("accept did not lead to busy");
  // start pulse for every accepted command
  a_start_pulse: assert property (s_accepted |-> cmd_start_o) // [R17]
    else $error("start pulse missing");
  // new class is latched on accept
  a_class_load: assert property (accept |=> cls_ff == $past(new_cls)) // [R17]
    else $error("class not latched");
  // force ends a running command
  a_force_idle: assert property (cmd_wr && is_force && !accept |=> !busy) // [R17]
    else $error("force left busy");
  // force leaves the flags as they are
  a_force_keeps: assert property (cmd_wr && is_force && !(|ev_hit) |=> $stable(cur)) // [R17]
    else $error("force changed flags");
  // a refused command gives no start
  a_refuse_no_start: assert property (refuse |-> !cmd_start_o) // [R02]
    else $error("refused command started");
  // refusal is reported in interrupt status
  a_refuse_flag: assert property (refuse |=> istat_ff[`DCS_IRQ_REFUSED]) // [R02]
    else $error("refusal not flagged");
  // master reset forces not ready
  a_mr_nrdy: assert property (mr_q_ff |-> st_word[`DCS_BIT_NRDY]) // [R01]
    else $error("master reset not seen");
  // busy bit follows the state machine
  a_busy_bit: assert property (st_word[`DCS_BIT_BUSY] == busy) // [R09]
    else $error("busy bit wrong");
  // completion raises the done interrupt
  a_done_irq: assert property (busy && done && !accept |=> istat_ff[`DCS_IRQ_DONE]) // [R09]
    else $error("done not flagged");
  // seek class protect bit
  a_prot_step: assert property (c_step |-> st_word[`DCS_BIT_PROT] == ~drv.wprot_n) // [R03]
    else $error("seek protect wrong");
  // seek class error bit
  a_seek_step: assert property (c_step |-> st_word[`DCS_BIT_SEEK] == seek_ff) // [R05]
    else $error("seek error bit wrong");
  // seek error event lands even in an accept cycle
  a_seek_set: assert property (event_i[`DCS_EV_SEEK_ERR] |=> seek_ff) // [R05]
    else $error("seek error lost");
  // seek class crc bit
  a_crc_step: assert property (c_step |-> st_word[`DCS_BIT_CRC] == crc_ff) // [R06]
    else $error("seek crc bit wrong");
  // seek class track zero bit
  a_trk_step: assert property (c_step |-> st_word[`DCS_BIT_TRK] == ~drv.trk0_n) // [R07]
    else $error("track zero bit wrong");
  // seek class index bit
  a_idx_step: assert property (c_step |-> st_word[`DCS_BIT_IDX] == ~drv.index_n) // [R08]
    else $error("index bit wrong");
  // write class protect bit
  a_wr_prot: assert property (c_wr |-> st_word[`DCS_BIT_PROT] == wprot_ff) // [R10]
    else $error("write protect bit wrong");
  // sector read record type
  a_rec_type: assert property (c_rsec |-> st_word[`DCS_BIT_HEAD] == del_ff) // [R11]
    else $error("record type wrong");
  // address read has no record type
  a_radr_head: assert property (c_radr |-> !st_word[`DCS_BIT_HEAD]) // [R11]
    else $error("address read bit 5 set");
  // write class fault bit
  a_wr_fault: assert property (c_wr |-> st_word[`DCS_BIT_HEAD] == wflt_ff) // [R12]
    else $error("write fault bit wrong");
  // record not found on id commands
  a_rnf_bit: assert property (c_id |-> st_word[`DCS_BIT_SEEK] == rnf_ff) // [R13]
    else $error("rnf bit wrong");
  // track write commands never show rnf or crc
  a_trk_no_rnf: assert property (c_wtrk |-> !st_word[`DCS_BIT_SEEK] && !st_word[`DCS_BIT_CRC]) // [R13]
    else $error("track write rnf set");
  // crc bit on id commands
  a_crc_bit: assert property (c_id |-> st_word[`DCS_BIT_CRC] == crc_ff) // [R14]
    else $error("crc bit wrong");
  // lost data bit outside seek class
  a_lost_bit: assert property (!c_step |-> st_word[`DCS_BIT_TRK] == lost_ff) // [R15]
    else $error("lost data bit wrong");
  // data request bit cleared by a new read or write command
  a_drq_clear: assert property (accept && !is_step |=> !st_word[`DCS_BIT_IDX]) // [R16]
    else $error("data request not cleared");
  // status register refuses writes
  a_status_wr_err: assert property (acc && pwrite_i && hit_stat |-> pslverr_o) // [R18]
    else $error("status write accepted");
  // unmapped addresses are errors
  a_unmapped_err: assert property (acc && !mapped |-> pslverr_o) // [R18]
    else $error("unmapped access accepted");
endmodule // dcs_status

// *** verification/dcs_host.sv ***
// Purpose: apb host model issuing single transfers to the status block
// Assumes: slave answers with pready; the bench watchdog bounds every wait
// Notes: signals change only right after a rising edge
`timescale 1ns/1ps
module dcs_host (
  input wire logic mclk_i,
  input wire logic pready_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  // idle bus from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end
  // setup, then access held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    @(posedge mclk_i);
    while (pready_i !== 1'b1) @(posedge mclk_i);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule // dcs_host

// *** verification/disk_controller_status_register_bench.sv ***
// Purpose: self-checking bench for the controller status word
// Assumes: drive pins need about four cycles through the synchronisers
// Notes: apb results are noted in a queue and checked by a monitor
`timescale 1ns/1ps
`include "dcs_consts.svh"
module disk_controller_status_register_bench;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } dcs_note_type;
  dcs_note_type notes[$];
  dcs_note_type mon_n;
  int num_errors = 0;
  int check_count = 0;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, cmd_start, irq, irq_a;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [2:0] cmd_class, cls;
  logic mr = 1'b0, rdy = 1'b0, wp_n = 1'b1, head_load_timing_in = 1'b0, t0_n = 1'b1;
  logic ix_n = 1'b1, head_load_out = 1'b0, data_request_out = 1'b0;
  logic [7:0] ev = 8'h00, e;
  dcs_host host (.mclk_i(mclk_i), .pready_i(pready), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  dcs_status dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .master_reset_in_i(mr), .drive_ready_i(rdy), .write_protect_in_n_i(wp_n),
    .head_load_timing_in_i(head_load_timing_in), .track_zero_in_n_i(t0_n), .index_pulse_in_n_i(ix_n),
    .head_load_out_i(head_load_out), .data_request_out_i(data_request_out), .event_i(ev),
    .cmd_start_o(cmd_start), .cmd_class_o(cmd_class), .irq_o(irq));
  // free-running 10 MHz clock
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // expected word per class; events as the sequencer pulses them
  function automatic logic [7:0] expect_word(input logic [2:0] c, input logic [7:0] x);
    logic [7:0] s;
    s = {~rdy | mr, 6'h00, 1'b1};
    case (c)
      3'h0: s[6:1] = {~wp_n, head_load_out & head_load_timing_in, x[1], x[2], ~t0_n, ~ix_n};
      3'h1: s[6:1] = {2'b00, x[3], x[2], x[6], data_request_out};
      3'h2: s[6:1] = {1'b0, x[4], x[3], x[2], x[6], data_request_out};
      3'h3: s[6:1] = {4'h0, x[6], data_request_out};
      3'h4: s[6:1] = {x[7], x[5], x[3], x[2], x[6], data_request_out};
      default: s[6:1] = {x[7], x[5], 2'b00, x[6], data_request_out};
    endcase
    return s;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic er);
    notes.push_back('{32'h0, 32'h0, er});
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic er);
    notes.push_back('{d, m, er});
    host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic pulse(input logic [7:0] x);
    @(posedge mclk_i);
    ev <= x;
    @(posedge mclk_i);
    ev <= 8'h00;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, x, g);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // oldest note against each completed transfer, taken at its edge
  always @(posedge mclk_i) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      mon_n = notes.pop_front();
      check_count++;
      if (((prdata & mon_n.m) !== (mon_n.d & mon_n.m)) || (pslverr !== mon_n.e)) begin
        num_errors++;
        $display("CHECK FAILED apb %h exp %h/%b seen %h/%b", paddr, mon_n.d, mon_n.e,
          prdata, pslverr);
      end
    end
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(30000 * 100);
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h89b5));
    cyc(4);
    sys_rst_i <= 1'b0;
    cyc(6);
    rd(`DCS_ADDR_STATUS, 32'h80, 32'hff, 1'b0);
    wr(`DCS_ADDR_CMD, 32'h0, 1'b0);
    rd(`DCS_ADDR_STATUS, 32'h81, 32'h81, 1'b0);
    pulse(8'h01);
    wr(`DCS_ADDR_IRQ_STAT, 32'h7, 1'b0);
    wr(`DCS_ADDR_CMD, 32'h2, 1'b0);
    rd(`DCS_ADDR_STATUS, 32'h80, 32'h81, 1'b0);
    rd(`DCS_ADDR_IRQ_STAT, 32'h2, 32'h2, 1'b0);
    // mask must change the interrupt line, clearing must drop it
    wr(`DCS_ADDR_IRQ_MASK, 32'h7, 1'b0);
    @(negedge mclk_i);
    irq_a = irq;
    wr(`DCS_ADDR_IRQ_MASK, 32'h0, 1'b0);
    @(negedge mclk_i);
    chk("irq mask", {31'h0, ~irq_a}, {31'h0, irq});
    wr(`DCS_ADDR_IRQ_STAT, 32'h2, 1'b0);
    rd(`DCS_ADDR_IRQ_STAT, 32'h0, 32'h2, 1'b0);
    wr(`DCS_ADDR_IRQ_MASK, 32'h7, 1'b0);
    @(negedge mclk_i);
    chk("irq clear", 32'h0, {31'h0, irq});
    rdy <= 1'b1;
    // every class but force twice, random pins and events; each accept clears old flags
    for (int i = 0; i < 12; i++) begin
      cls = 3'(i % 6);
      rnd = $urandom();
      {wp_n, head_load_timing_in, t0_n, ix_n, head_load_out} <= rnd[4:0];
      data_request_out <= 1'b0;
      e = rnd[15:8] & 8'hfe;
      cyc(6);
      wr(`DCS_ADDR_CMD, {29'h0, cls}, 1'b0);
      @(negedge mclk_i);
      chk("class", {29'h0, cls}, {29'h0, cmd_class});
      pulse(e);
      data_request_out <= rnd[5];
      cyc(6);
      rd(`DCS_ADDR_STATUS, {24'h0, expect_word(cls, e)}, 32'hff, 1'b0);
      pulse(8'h01);
      rd(`DCS_ADDR_STATUS, 32'h0, 32'h1, 1'b0);
    end
    // force ends busy and keeps flags; lost data raises its interrupt
    wr(`DCS_ADDR_IRQ_STAT, 32'h7, 1'b0);
    wr(`DCS_ADDR_CMD, 32'h0, 1'b0);
    pulse(8'h42);
    wr(`DCS_ADDR_CMD, 32'h6, 1'b0);
    rd(`DCS_ADDR_STATUS, 32'h10, 32'h91, 1'b0);
    rd(`DCS_ADDR_IRQ_STAT, 32'h4, 32'h4, 1'b0);
    wr(`DCS_ADDR_IRQ_STAT, 32'h7, 1'b0);
    @(negedge mclk_i);
    chk("irq lost", 32'h0, {31'h0, irq});
    wr(`DCS_ADDR_STATUS, 32'hff, 1'b1);
    rd(`DCS_ADDR_STATUS, {24'h0, expect_word(3'h0, 8'h02) & 8'hfe}, 32'hff, 1'b0);
    rd(`DCS_ADDR_EVENT, 32'h0, 32'hffff_ffff, 1'b0);
    rd(12'h020, 32'h0, 32'h0, 1'b1);
    mr <= 1'b1;
    cyc(6);
    rd(`DCS_ADDR_STATUS, 32'h80, 32'h80, 1'b0);
    give_verdict();
  end
endmodule // disk_controller_status_register_bench
